// >>> rtl/dac_serial_pkg.sv
// shared constants and carrier types for the serial converter input port
`default_nettype none
package dac_serial_pkg;
    localparam int WORD_W = 16;
    localparam int DATA_W = 12;
    localparam int MODE_HI_POS = 13;
    localparam int MODE_LO_POS = 12;
    localparam int SYNC_STAGES = 3;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PD_1K = 2'h1;
    localparam logic [1:0] MODE_PD_100K = 2'h2;
    localparam logic [1:0] MODE_PD_HIZ = 2'h3;
    localparam int SCLK_PERIOD_NS = 160;
    localparam int CORE_PERIOD_NS = 20;
    // core cycles per link clock period, used for bench guidance only
    localparam int SCLK_CYCLES = SCLK_PERIOD_NS / CORE_PERIOD_NS;

    typedef struct packed {
        logic [1:0] pwrdn_sel;
        logic [11:0] code;
    } dac_word_t;
endpackage
`default_nettype wire

// >>> rtl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only when the two settled stages agree
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            level_o <= RESET_VAL;
        end else if (s2_reg == s3_reg) begin
            level_o <= s3_reg;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/dac_serial_port.sv
// serial input port with daisy-chain output for a 12-bit converter
`default_nettype none
module dac_serial_port
    import dac_serial_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic serial_in_i,
    input wire logic async_clear_n_i,
    output logic chain_serial_out_o,
    output logic chain_serial_out_oe_o,
    output logic [11:0] dac_code_o,
    output logic [1:0] pwrdn_sel_o,
    output logic powered_down_o,
    output logic update_o
);
    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic sclk_s;
    logic sync_n_s;
    logic serial_in_s;
    logic clr_n_s;
    logic sclk_prev_reg;
    logic sync_prev_reg;
    logic [15:0] shift_reg;
    dac_word_t word_reg;

    // serial clock idles high, so reset to that level to avoid a false fall
    pin_sync #(.RESET_VAL(1'b1)) u_sclk (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pin_i(sclk_i),
        .level_o(sclk_s)
    );
    pin_sync #(.RESET_VAL(1'b1)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pin_i(sync_n_i),
        .level_o(sync_n_s)
    );
    pin_sync #(.RESET_VAL(1'b0)) u_serial_in (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pin_i(serial_in_i),
        .level_o(serial_in_s)
    );
    // clear is sampled too; a short pulse below the filter depth is lost,
    // the price of one clock domain
    pin_sync #(.RESET_VAL(1'b1)) u_clr (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pin_i(async_clear_n_i),
        .level_o(clr_n_s)
    );

    logic sclk_fall;
    logic sync_rise;
    logic clear;
    assign sclk_fall = sclk_prev_reg & ~sclk_s;
    assign sync_rise = ~sync_prev_reg & sync_n_s;
    assign clear = ~clr_n_s;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sclk_prev_reg <= 1'b1;
            sync_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk_s;
            sync_prev_reg <= sync_n_s;
        end
    end

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    // shift msb first on falling edge while sync low
    // clear wipes the shift register as well
    always_ff @(posedge core_clk_i) begin
        if (rst_i || clear) begin
            shift_reg <= WORD_RESET;
        end else if (!sync_n_s && sclk_fall) begin
            shift_reg <= {shift_reg[WORD_W-2:0], serial_in_s};
        end
    end

    // ------------------------------------------------------------
    // chain output
    // ------------------------------------------------------------
    // drive shift register end only while sync low
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            chain_serial_out_o <= 1'b0;
            chain_serial_out_oe_o <= 1'b0;
        end else begin
            chain_serial_out_o <= shift_reg[WORD_W-1];
            chain_serial_out_oe_o <= ~sync_n_s;
        end
    end

    // ------------------------------------------------------------
    // converter register
    // ------------------------------------------------------------
    // one decode shared by the flag and the code blanking
    function automatic logic mode_is_off(input logic [1:0] sel);
        return sel != MODE_NORMAL;
    endfunction

    // latch the low fourteen bits of the register; the top two bits are dropped
    // reset and clear give zero scale, normal mode
    always_ff @(posedge core_clk_i) begin
        if (rst_i || clear) begin
            word_reg <= '{pwrdn_sel: MODE_NORMAL, code: CODE_RESET};
            update_o <= 1'b0;
        end else begin
            update_o <= sync_rise;
            if (sync_rise) begin
                word_reg.pwrdn_sel <= shift_reg[MODE_HI_POS:MODE_LO_POS];
                word_reg.code <= shift_reg[DATA_W-1:0];
            end
        end
    end

    // code passes straight binary; zero while powered down
    always_ff @(posedge core_clk_i) begin
        if (rst_i || clear) begin
            dac_code_o <= CODE_RESET;
            pwrdn_sel_o <= MODE_NORMAL;
            powered_down_o <= 1'b0;
        end else begin
            pwrdn_sel_o <= word_reg.pwrdn_sel;
            powered_down_o <= mode_is_off(word_reg.pwrdn_sel);
            dac_code_o <= mode_is_off(word_reg.pwrdn_sel) ? CODE_RESET : word_reg.code;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    chk_shift_idle: assert property (
        sync_n_s && !clear |=> $stable(shift_reg))
        else $error("shift register moved while sync high");
    chk_shift_edge: assert property (
        !sync_n_s && sclk_fall && !clear |=> shift_reg == {$past(shift_reg[14:0]), $past(serial_in_s)})
        else $error("falling edge did not shift one bit");
    chk_latch_word: assert property (
        sync_rise && !clear |=> word_reg == $past(shift_reg[13:0]))
        else $error("sync rise did not latch word");
    chk_out_hiz: assert property (
        sync_n_s |=> !chain_serial_out_oe_o)
        else $error("chain output driven while sync high");
    chk_out_delay: assert property (
        !sync_n_s |=> chain_serial_out_oe_o && chain_serial_out_o == $past(shift_reg[15]))
        else $error("chain output not shift register end");
    chk_pd_mode: assert property (
        word_reg.pwrdn_sel != MODE_NORMAL && !clear |=> powered_down_o && dac_code_o == 12'h000)
        else $error("power-down mode did not blank code");
    chk_normal_code: assert property (
        word_reg.pwrdn_sel == MODE_NORMAL && !clear |=> dac_code_o == $past(word_reg.code))
        else $error("normal mode code not passed");
    chk_clear_zero: assert property (
        clear |=> dac_code_o == 12'h000 && !powered_down_o && shift_reg == 16'h0000)
        else $error("clear did not zero registers");
    chk_word_hold: assert property (
        !sync_rise && !clear |=> $stable(word_reg))
        else $error("word changed without sync rise");
    chk_update_cause: assert property (
        sync_rise && !clear |=> update_o)
        else $error("sync rise gave no update pulse");
    chk_update_once: assert property (
        update_o |=> !update_o)
        else $error("update pulse lasted more than one cycle");
    chk_out_hold: assert property (
        !update_o && !clear |=> $stable(dac_code_o) && $stable(pwrdn_sel_o))
        else $error("outputs moved without an update");
    chk_mode_follow: assert property (
        !clear |=> pwrdn_sel_o == $past(word_reg.pwrdn_sel)
            && powered_down_o == ($past(word_reg.pwrdn_sel) != MODE_NORMAL))
        else $error("mode outputs do not follow latched word");
    chk_reset_zero: assert property (
        disable iff (1'b0) rst_i |=> dac_code_o == 12'h000 && !powered_down_o
            && !update_o && shift_reg == 16'h0000)
        else $error("reset did not clear registers");
    chk_clear_noupd: assert property (
        clear |=> !update_o)
        else $error("update pulse while clear held");

    cov_update: cover property (update_o);
    cov_pd_hiz: cover property (pwrdn_sel_o == MODE_PD_HIZ);
    cov_clear: cover property (clear ##1 !clear);
    cov_chain: cover property (chain_serial_out_oe_o && chain_serial_out_o);
    cov_pd_100k: cover property (pwrdn_sel_o == MODE_PD_100K);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the slices above assume this exact word layout
    if (WORD_W != 16 || DATA_W != 12) begin : g_bad_width
        $error("word must be sixteen bits with twelve data bits");
    end
    if (MODE_HI_POS != MODE_LO_POS + 1 || MODE_LO_POS != DATA_W) begin : g_bad_mode
        $error("mode field must sit directly above the data field");
    end
    if (SYNC_STAGES != 3) begin : g_bad_sync
        $error("pin filter is built for three stages");
    end
endmodule
`default_nettype wire

// >>> sim/spi_host_model.sv
// host-side serial master model that drives the converter port
`default_nettype none
module spi_host_model (
    input wire logic core_clk_i,
    input wire logic chain_in_i,
    input wire logic chain_oe_i,
    output logic sclk_o,
    output logic sync_n_o,
    output logic serial_in_o,
    output logic [31:0] cap_o,
    output logic oe_all_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_o = 1'b1;
        sync_n_o = 1'b1;
        serial_in_o = 1'b0;
        cap_o = 32'h0;
        oe_all_o = 1'b1;
    end
    // msb first, n falls at 6.25 MHz
    // en low keeps sync high, to show that clocks outside a frame are ignored
    task automatic frame(input logic [31:0] w, input int n, input bit en);
        sync_n_o = !en;
        oe_all_o = 1'b1;
        repeat (8) @(negedge core_clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_o = w[i];
            repeat (4) @(negedge core_clk_i);
            cap_o = {cap_o[30:0], chain_in_i};
            oe_all_o = oe_all_o & chain_oe_i;
            sclk_o = 1'b0;
            repeat (4) @(negedge core_clk_i);
            sclk_o = 1'b1;
        end
        repeat (4) @(negedge core_clk_i);
        sync_n_o = 1'b1;
        // no pull resistor on the data line, so it must not keep its last value
        serial_in_o = !serial_in_o;
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the serial converter input port
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clr_n = 1'b1;
    logic sclk, sync_n, serial_in, so, so_oe, pd, upd, oe_all;
    logic [11:0] code;
    logic [1:0] mode;
    logic [31:0] cap;
    int num_errors = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    dac_serial_port u_dut (.core_clk_i(clk), .rst_i(rst), .sclk_i(sclk), .sync_n_i(sync_n),
        .serial_in_i(serial_in), .async_clear_n_i(clr_n), .chain_serial_out_o(so),
        .chain_serial_out_oe_o(so_oe), .dac_code_o(code), .pwrdn_sel_o(mode),
        .powered_down_o(pd), .update_o(upd));
    spi_host_model u_host (.core_clk_i(clk), .chain_in_i(so), .chain_oe_i(so_oe),
        .sclk_o(sclk), .sync_n_o(sync_n), .serial_in_o(serial_in), .cap_o(cap), .oe_all_o(oe_all));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // bounded wait for the latch pulse; it must last one cycle only
    task automatic await_update(input bit want);
        bit seen;
        seen = 1'b0;
        for (int k = 0; k < 20 && !seen; k++) begin
            @(negedge clk);
            seen = (upd === 1'b1);
        end
        @(negedge clk);
        check({30'h0, seen, upd}, {30'h0, want, 1'b0});
        @(negedge clk);
    endtask
    task automatic check_out(input logic [1:0] m, input logic [11:0] c);
        check({17'h0, pd, mode, code}, {17'h0, m != 2'h0, m, c});
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check_out(2'h0, 12'h000);
        check({30'h0, so_oe, so}, 32'h0);
        u_host.frame({16'h0, 16'hCABC}, 16, 1'b1);
        await_update(1'b1);
        check_out(2'h0, 12'hABC);
        for (int m = 0; m < 4; m++) begin
            u_host.frame({16'h0, 2'b10, m[1:0], 12'hFFF}, 16, 1'b1);
            await_update(1'b1);
            check_out(m[1:0], m == 0 ? 12'hFFF : 12'h000);
        end
        u_host.frame({16'h0, 16'h0555}, 16, 1'b0);
        await_update(1'b0);
        check_out(2'h3, 12'h000);
        u_host.frame({16'h5A3C, 16'h0C4B}, 32, 1'b1);
        await_update(1'b1);
        check_out(2'h0, 12'hC4B);
        check(cap, {16'hBFFF, 16'h5A3C});
        check({31'h0, oe_all}, 32'h1);
        check({31'h0, so_oe}, 32'h0);
        u_host.frame({24'h0, 8'hE7}, 8, 1'b1);
        await_update(1'b1);
        check_out(2'h0, 12'hBE7);
        clr_n = 1'b0;
        repeat (6) @(negedge clk);
        check_out(2'h0, 12'h000);
        clr_n = 1'b1;
        repeat (4) @(negedge clk);
        u_host.frame({24'h0, 8'h5A}, 8, 1'b1);
        await_update(1'b1);
        check_out(2'h0, 12'h05A);
        u_host.frame({16'h0, 16'h07FF}, 16, 1'b1);
        await_update(1'b1);
        check_out(2'h0, 12'h7FF);
        print_verdict();
    end
    // whole run is near 30 us, so this only fires on a hang
    initial begin
        #200us;
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
